/* File: bench/move_rotate_checker_sva.sv */
// ************************************************************
// port-level timing checker
// ************************************************************
module move_rotate_checker
    import move_rotate_pkg::*;
(
    input wire logic       clock,      // core clock
    input wire logic       resetn,     // async reset, low active
    input wire logic [7:0] code_byte,  // fetched byte
    input wire logic       code_valid, // fetch offers
    input wire logic       code_ready, // core accepts
    input wire logic [7:0] acc,        // accumulator
    input wire logic       carry,      // carry flag
    input wire logic       instr_done, // completion pulse
    input wire logic       unknown_op  // skip pulse
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);

    logic       take;  // byte accepted this edge
    logic       opc;   // accepted byte is an opcode
    logic [1:0] left;  // operand bytes still owed

    // operand bytes following an opcode
    function automatic logic [1:0] extra(input logic [7:0] b);
        if (b == OPC_DIRECT_DIRECT) return 2'h2;
        if (b == OPC_A_DIRECT || b == OPC_DIRECT_A) return 2'h1;
        if ((b & MASK_RN) == OPC_RN_IMM || (b & MASK_RN) == OPC_RN_DIRECT) return 2'h1;
        if ((b & MASK_RN) == OPC_DIRECT_RN) return 2'h1;
        return 2'h0;
    endfunction

    assign take = code_valid && code_ready;
    assign opc  = take && (left == 2'h0);

    // byte-position tracker, needed since opcodes and operands share one port
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            left <= 2'h0;
        end else if (take) begin
            left <= (left != 2'h0) ? left - 2'h1 : extra(code_byte);
        end
    end

    sequence s_two;
        opc && extra(code_byte) == 2'h1 ##1 take;
    endsequence
    sequence s_three;
        opc && code_byte == OPC_DIRECT_DIRECT ##1 take ##1 take;
    endsequence

    property p_rotate;
        opc && code_byte == OPC_ROTATE |=> instr_done && carry == $past(acc[0])
            && acc == {$past(carry), $past(acc[7:1])};
    endproperty
    property p_two;
        s_two |=> instr_done;
    endproperty
    property p_three;
        s_three |=> instr_done;
    endproperty
    property p_indirect;
        opc && (code_byte & MASK_RI) == OPC_A_INDIRECT
            |=> !code_ready && !instr_done ##1 code_ready && instr_done;
    endproperty
    property p_ready_low;
        !code_ready |-> $past(opc && (code_byte & MASK_RI) == OPC_A_INDIRECT);
    endproperty
    property p_no_early;
        opc && extra(code_byte) != 2'h0 |=> !instr_done;
    endproperty
    property p_unknown;
        unknown_op |-> instr_done;
    endproperty
    property p_store_acc;
        opc && code_byte == OPC_DIRECT_A |=> $stable(acc) [*2];
    endproperty

    a_rotate: assert property (p_rotate) else $error("rotate result or timing wrong");
    a_two: assert property (p_two) else $error("two byte op not done in 2");
    a_three: assert property (p_three) else $error("direct copy not done in 3");
    a_indirect: assert property (p_indirect) else $error("indirect load not 2 cycles");
    a_ready_low: assert property (p_ready_low) else $error("stray ready drop");
    a_no_early: assert property (p_no_early) else $error("done too early");
    a_unknown: assert property (p_unknown) else $error("skip without done");
    a_store_acc: assert property (p_store_acc) else $error("store altered acc");
endmodule

bind move_rotate_instruction_timing move_rotate_checker move_rotate_checker_inst (
    .clock      (clock),
    .resetn     (resetn),
    .code_byte  (code_byte),
    .code_valid (code_valid),
    .code_ready (code_ready),
    .acc        (acc),
    .carry      (carry),
    .instr_done (instr_done),
    .unknown_op (unknown_op)
);

/* File: bench/tb_move_rotate_instruction_timing.sv */
module tb_move_rotate_instruction_timing;
    timeunit 1ns;
    timeprecision 100ps;
    import move_rotate_pkg::*;

    logic       clock;      // 250 MHz core clock
    logic       resetn;     // low active reset
    logic [7:0] code_byte;  // fetch byte
    logic       code_valid; // fetch valid
    logic       code_ready; // core accepts
    logic [1:0] bank_sel;   // active bank
    logic [7:0] peek_addr;  // observed address
    logic [7:0] peek_data;  // observed byte
    logic [7:0] acc;        // accumulator
    logic       carry;      // carry flag
    logic       instr_done; // done pulse
    logic       unknown_op; // skip pulse
    int         failures;   // mismatches
    int         checks;     // comparisons

    move_rotate_instruction_timing move_rotate_instruction_timing_inst (
        .clock      (clock),
        .resetn     (resetn),
        .code_byte  (code_byte),
        .code_valid (code_valid),
        .code_ready (code_ready),
        .bank_sel   (bank_sel),
        .peek_addr  (peek_addr),
        .peek_data  (peek_data),
        .acc        (acc),
        .carry      (carry),
        .instr_done (instr_done),
        .unknown_op (unknown_op)
    );

    // ************************************************************
    // clock and helpers
    // ************************************************************
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task end_sim;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // offer one byte at a falling edge, hold until an edge with ready takes it
    task feed(input logic [7:0] b);
        int k;
        k = 0;
        code_byte  = b;
        code_valid = 1'b1;
        while (code_ready !== 1'b1 && k < 4) begin
            @(negedge clock);
            k++;
        end
        // ready still low after the bound: count it and report at once
        if (code_ready !== 1'b1) begin
            failures++;
            end_sim();
        end else begin
            @(negedge clock);
        end
    endtask

    // bytes go back to back, then the stream idles so results land
    task prog(input logic [7:0] b0, b1, b2, input int n);
        feed(b0);
        if (n > 1) feed(b1);
        if (n > 2) feed(b2);
        code_valid = 1'b0;
        repeat (2) @(negedge clock);
    endtask

    task peek(input logic [7:0] a, input logic [7:0] exp);
        peek_addr = a;
        @(negedge clock);
        chk("ram", exp, peek_data);
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task t_imm;
        bank_sel = 2'h1;
        prog(OPC_RN_IMM | 8'h03, 8'hA5, 8'h00, 2);
        peek(8'h0B, 8'hA5);
        bank_sel = 2'h2;
        prog(OPC_RN_IMM | 8'h02, 8'h3C, 8'h00, 2);
        peek(8'h12, 8'h3C);
        $display("test imm done");
    endtask

    task t_copy_load;
        prog(OPC_DIRECT_DIRECT, 8'h0B, 8'h40, 3);
        peek(8'h40, 8'hA5);
        prog(OPC_A_DIRECT, 8'h40, 8'h00, 2);
        chk("acc", 8'hA5, acc);
        $display("test copy done");
    endtask

    task t_rotate;
        prog(OPC_ROTATE, OPC_ROTATE, 8'h00, 2);
        chk("acc", 8'hA9, acc);
        chk("carry", 8'h00, {7'h00, carry});
        prog(OPC_ROTATE, 8'h00, 8'h00, 1);
        chk("carry", 8'h01, {7'h00, carry});
        $display("test rotate done");
    endtask

    task t_store;
        bank_sel = 2'h1;
        prog(OPC_DIRECT_A, 8'h50, 8'h00, 2);
        peek(8'h50, 8'h54);
        prog(OPC_DIRECT_RN | 8'h03, 8'h51, 8'h00, 2);
        peek(8'h51, 8'hA5);
        prog(OPC_RN_DIRECT | 8'h05, 8'h50, 8'h00, 2);
        peek(8'h0D, 8'h54);
        $display("test store done");
    endtask

    task t_indirect;
        bank_sel = 2'h1;
        prog(OPC_RN_IMM, 8'h40, OPC_RN_IMM | 8'h01, 3);
        prog(8'h12, OPC_A_INDIRECT, OPC_A_INDIRECT | 8'h01, 3);
        chk("acc", 8'h3C, acc);
        prog(OPC_A_INDIRECT, 8'h00, 8'h00, 1);
        chk("acc", 8'hA5, acc);
        $display("test indirect done");
    endtask

    // skipped opcode, refused byte, then a reset in mid-instruction
    task t_skip;
        code_byte  = 8'h00;
        code_valid = 1'b1;
        @(negedge clock);
        code_valid = 1'b0;
        chk("unknown_op", 8'h01, {7'h00, unknown_op});
        chk("instr_done", 8'h01, {7'h00, instr_done});
        chk("acc", 8'hA5, acc);
        // indirect load: byte stays offered through the refused cycle
        code_byte  = OPC_A_INDIRECT;
        code_valid = 1'b1;
        @(negedge clock);
        chk("code_ready", 8'h00, {7'h00, code_ready});
        chk("instr_done", 8'h00, {7'h00, instr_done});
        chk("unknown_op", 8'h00, {7'h00, unknown_op});
        @(negedge clock);
        code_valid = 1'b0;
        chk("code_ready", 8'h01, {7'h00, code_ready});
        chk("instr_done", 8'h01, {7'h00, instr_done});
        chk("acc", 8'hA5, acc);
        // opcode taken, operand never comes: reset must drop it
        code_byte  = OPC_A_DIRECT;
        code_valid = 1'b1;
        @(negedge clock);
        code_valid = 1'b0;
        resetn     = 1'b0;
        @(negedge clock);
        chk("carry", {7'h00, CARRY_RESET}, {7'h00, carry});
        chk("acc", ACC_RESET, acc);
        chk("code_ready", 8'h01, {7'h00, code_ready});
        resetn = 1'b1;
        prog(OPC_A_DIRECT, 8'h40, 8'h00, 2);
        chk("acc", 8'hA5, acc);
        $display("test skip done");
    endtask

    initial begin
        failures   = 0;
        checks     = 0;
        resetn     = 1'b0;
        code_byte  = 8'h00;
        code_valid = 1'b0;
        bank_sel   = 2'h0;
        peek_addr  = 8'h00;
        repeat (5) @(negedge clock);
        resetn = 1'b1;
        chk("acc", ACC_RESET, acc);
        t_imm();
        t_copy_load();
        t_rotate();
        t_store();
        t_indirect();
        t_skip();
        end_sim();
    end
endmodule

/* File: rtl/decode_if.sv */
// opcode in, class and register field out
interface decode_if;
    import move_rotate_pkg::*;
    logic [7:0] opcode;    // byte under decode
    op_class_t  op_class;  // what it does
    logic [2:0] reg_sel;   // register or pointer index

    modport classifier (input opcode, output op_class, output reg_sel);
    modport user       (output opcode, input op_class, input reg_sel);
endinterface

/* File: rtl/move_rotate_instruction_timing.sv */
// Summary of operation
// - rotate acc right through carry, 1 cycle
// - direct byte into acc, 2 bytes/cycles
// - acc from ram at pointer, 2 cycles
// - immediate into working register, 2 cycles
// - direct byte into working register, 2 cycles
// - acc stored to direct byte, 2 cycles
// - working register stored to direct byte
// - direct to direct copy, 3 bytes/cycles
module move_rotate_instruction_timing
    import move_rotate_pkg::*;
(
    input  wire logic       clock,      // core clock
    input  wire logic       resetn,     // async reset, low active
    input  wire logic [7:0] code_byte,  // instruction byte from fetch
    input  wire logic       code_valid, // fetch offers a byte
    output logic            code_ready, // byte taken this cycle when valid
    input  wire logic [1:0] bank_sel,   // active register bank
    input  wire logic [7:0] peek_addr,  // observation address
    output logic [7:0]      peek_data,  // byte at peek_addr, one cycle late
    output logic [7:0]      acc,        // accumulator
    output logic            carry,      // carry flag
    output logic            instr_done, // pulse after final cycle
    output logic            unknown_op  // pulse after a skipped opcode
);

    // ************************************************************
    // storage and decode
    // ************************************************************
    logic [7:0] ram [RAM_DEPTH];   // direct and indirect byte space
    state_t     state;             // sequencer state
    state_t     next_state;        // its next value
    logic [7:0] op_reg;            // held opcode past the first byte
    logic [7:0] src_addr;          // source of direct to direct copy
    logic [7:0] ptr;               // pointer value for indirect load
    logic       take;              // a code byte is consumed
    logic       wr_en;             // ram write this cycle
    logic [7:0] wr_addr;           // ram write address
    logic [7:0] wr_data;           // ram write data
    logic [7:0] rn_addr;           // active bank working register
    logic       last_cycle;        // final cycle of an instruction

    decode_if dec ();              // opcode classification

    // first cycle decodes the live byte, later ones the held opcode
    assign dec.opcode = (state == ST_OPCODE) ? code_byte : op_reg;

    opcode_classifier opcode_classifier_inst (
        .dec (dec.classifier)
    );

    assign take = code_valid && code_ready;

    assign rn_addr = reg_address(bank_sel, dec.reg_sel);

    // ************************************************************
    // sequencer
    // ************************************************************

    // next state; a missing byte simply holds the state
    always_comb begin
        next_state = state;
        last_cycle = 1'b0;
        case (state)
            ST_OPCODE: begin
                if (take) begin
                    if (dec.op_class == OP_ROTATE || dec.op_class == OP_OTHER) begin
                        last_cycle = 1'b1;
                    end else if (dec.op_class == OP_A_INDIRECT) begin
                        next_state = ST_INDIRECT;
                    end else begin
                        next_state = ST_SECOND;
                    end
                end
            end
            ST_SECOND: begin
                if (take) begin
                    if (dec.op_class == OP_DIRECT_DIRECT) begin
                        next_state = ST_THIRD;
                    end else begin
                        next_state = ST_OPCODE;
                        last_cycle = 1'b1;
                    end
                end
            end
            ST_THIRD: begin
                if (take) begin
                    next_state = ST_OPCODE;
                    last_cycle = 1'b1;
                end
            end
            ST_INDIRECT: begin
                // no byte fetched here
                next_state = ST_OPCODE;
                last_cycle = 1'b1;
            end
            default: begin
                next_state = ST_OPCODE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state <= ST_OPCODE;
        end else begin
            state <= next_state;
        end
    end

    // fetch handshake; only the indirect cycle refuses a byte
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            code_ready <= 1'b1;
        end else begin
            code_ready <= (next_state != ST_INDIRECT);
        end
    end

    // held operands from earlier bytes
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            op_reg   <= 8'h00;
            src_addr <= 8'h00;
            ptr      <= 8'h00;
        end else begin
            if (state == ST_OPCODE && take) begin
                op_reg <= code_byte;
                ptr    <= ram[rn_addr];
            end
            if (state == ST_SECOND && take) begin
                src_addr <= code_byte;
            end
        end
    end

    // ************************************************************
    // datapath
    // ************************************************************

    // accumulator and carry
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            acc   <= ACC_RESET;
            carry <= CARRY_RESET;
        end else if (state == ST_OPCODE && take && dec.op_class == OP_ROTATE) begin
            acc   <= {carry, acc[7:1]};
            carry <= acc[0];
        end else if (state == ST_SECOND && take && dec.op_class == OP_A_DIRECT) begin
            acc <= ram[code_byte];
        end else if (state == ST_INDIRECT) begin
            acc <= ram[ptr];
        end
    end

    // ram write selection; one write port is enough for this group
    always_comb begin
        wr_en   = 1'b0;
        wr_addr = code_byte;
        wr_data = 8'h00;
        if (state == ST_SECOND && take) begin
            case (dec.op_class)
                OP_RN_IMM: begin
                    wr_en   = 1'b1;
                    wr_addr = rn_addr;
                    wr_data = code_byte;
                end
                OP_RN_DIRECT: begin
                    wr_en   = 1'b1;
                    wr_addr = rn_addr;
                    wr_data = ram[code_byte];
                end
                OP_DIRECT_A: begin
                    wr_en   = 1'b1;
                    wr_data = acc;
                end
                OP_DIRECT_RN: begin
                    wr_en   = 1'b1;
                    wr_data = ram[rn_addr];
                end
                default: begin
                    wr_en = 1'b0;
                end
            endcase
        end else if (state == ST_THIRD && take) begin
            wr_en   = 1'b1;
            wr_data = ram[src_addr];
        end
    end

    // ram array; contents are not reset, software must initialise them
    always_ff @(posedge clock) begin
        if (wr_en) begin
            ram[wr_addr] <= wr_data;
        end
    end

    // ************************************************************
    // status and observation
    // ************************************************************

    // completion and skipped-opcode pulses
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            instr_done <= 1'b0;
            unknown_op <= 1'b0;
        end else begin
            instr_done <= last_cycle;
            unknown_op <= (state == ST_OPCODE) && take && (dec.op_class == OP_OTHER);
        end
    end

    // registered peek port, sees writes of the previous edge
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            peek_data <= 8'h00;
        end else begin
            peek_data <= ram[peek_addr];
        end
    end

endmodule

/* File: rtl/move_rotate_pkg.sv */
package move_rotate_pkg;

    // ************************************************************
    // opcode encodings
    // ************************************************************
    localparam logic [7:0] OPC_ROTATE        = 8'h13; // rotate right via carry
    localparam logic [7:0] OPC_A_DIRECT      = 8'hE5; // acc from direct byte
    localparam logic [7:0] OPC_A_INDIRECT    = 8'hE6; // acc from ram at pointer, low bit picks it
    localparam logic [7:0] OPC_RN_IMM        = 8'h78; // working reg from immediate
    localparam logic [7:0] OPC_RN_DIRECT     = 8'hA8; // working reg from direct byte
    localparam logic [7:0] OPC_DIRECT_A      = 8'hF5; // direct byte from acc
    localparam logic [7:0] OPC_DIRECT_RN     = 8'h88; // direct byte from working reg
    localparam logic [7:0] OPC_DIRECT_DIRECT = 8'h85; // direct byte to direct byte
    localparam logic [7:0] MASK_RN           = 8'hF8; // low three bits pick the register
    localparam logic [7:0] MASK_RI           = 8'hFE; // low bit picks the pointer

    // ************************************************************
    // sizes and reset values
    // ************************************************************
    localparam int         RAM_DEPTH   = 256;   // whole direct/indirect byte space
    localparam logic [7:0] ACC_RESET   = 8'h00; // accumulator after reset
    localparam logic       CARRY_RESET = 1'b0;  // carry after reset

    // instruction classes seen by the sequencer
    typedef enum logic [3:0] {
        OP_ROTATE        = 4'h0,
        OP_A_DIRECT      = 4'h1,
        OP_A_INDIRECT    = 4'h2,
        OP_RN_IMM        = 4'h3,
        OP_RN_DIRECT     = 4'h4,
        OP_DIRECT_A      = 4'h5,
        OP_DIRECT_RN     = 4'h6,
        OP_DIRECT_DIRECT = 4'h7,
        OP_OTHER         = 4'h8
    } op_class_t;

    // sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_OPCODE   = 4'b0001,
        ST_SECOND   = 4'b0010,
        ST_THIRD    = 4'b0100,
        ST_INDIRECT = 4'b1000
    } state_t;

    // byte address of a working register in the active bank
    function automatic logic [7:0] reg_address(input logic [1:0] bank,
                                               input logic [2:0] index);
        reg_address = {3'b000, bank, index};
    endfunction

endpackage

/* File: rtl/opcode_classifier.sv */
module opcode_classifier
    import move_rotate_pkg::*;
(
    decode_if.classifier dec
);

    // ************************************************************
    // pure decode, no state
    // ************************************************************

    // match on masked opcodes; unknown codes fall to the other class
    always_comb begin
        dec.reg_sel = dec.opcode[2:0];
        if (dec.opcode == OPC_ROTATE) begin
            dec.op_class = OP_ROTATE;
        end else if (dec.opcode == OPC_A_DIRECT) begin
            dec.op_class = OP_A_DIRECT;
        end else if ((dec.opcode & MASK_RI) == OPC_A_INDIRECT) begin
            dec.op_class = OP_A_INDIRECT;
            dec.reg_sel  = {2'b00, dec.opcode[0]};
        end else if ((dec.opcode & MASK_RN) == OPC_RN_IMM) begin
            dec.op_class = OP_RN_IMM;
        end else if ((dec.opcode & MASK_RN) == OPC_RN_DIRECT) begin
            dec.op_class = OP_RN_DIRECT;
        end else if (dec.opcode == OPC_DIRECT_A) begin
            dec.op_class = OP_DIRECT_A;
        end else if ((dec.opcode & MASK_RN) == OPC_DIRECT_RN) begin
            dec.op_class = OP_DIRECT_RN;
        end else if (dec.opcode == OPC_DIRECT_DIRECT) begin
            dec.op_class = OP_DIRECT_DIRECT;
        end else begin
            dec.op_class = OP_OTHER;
        end
    end

endmodule
